// file: logic/tgp_ctrl.sv
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module tgp_ctrl #(
  parameter int DATA_W   = 16,
  parameter int FLUSH_1X = 16,
  parameter int FLUSH_2X = 64,
  parameter int FLUSH_4X = 128,
  parameter int FLUSH_8X = 256
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic [4:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  input  wire logic              transmit_gate,
  input  wire logic [DATA_W-1:0] data_port1,
  input  wire logic [DATA_W-1:0] data_port2,
  output logic                   word_clock_out,
  output logic [DATA_W-1:0]      i_word,
  output logic [DATA_W-1:0]      q_word,
  output logic                   pair_valid,
  output tgp_pkg::tgp_power_t    power
);
  // Register file
  logic [7:0]  ctrl_reg, ctrl_next;
  logic [7:0]  pwr_reg, pwr_next;
  logic [7:0]  gate_reg, gate_next;
  logic [15:0] mode_reg, mode_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        ack_reg, ack_next;
  logic        req;
  logic [2:0]  idx;
  logic [31:0] status;
  tgp_pkg::tgp_pwr_req_t preq;

  // Input synchronisers, two stages
  logic              gate_s1_reg, gate_s2_reg;
  logic [DATA_W-1:0] p1_s1_reg, p1_s2_reg, p2_s1_reg, p2_s2_reg;

  // Word clock divider
  logic [7:0] wdiv_reg, wdiv_next;
  logic       wclk_reg, wclk_next;
  logic       rise_en;

  // Power state machine
  tgp_pkg::tgp_state_t state_reg, state_next;
  logic [15:0] fcnt_reg, fcnt_next;
  logic [15:0] flush_lim;

  // Data path
  logic              pgate_reg, pgate_next;
  logic              sel_q_reg, sel_q_next;
  logic              aligned_reg, aligned_next;
  logic              haveq_reg, haveq_next;
  logic [DATA_W-1:0] hold_reg, hold_next;
  logic [DATA_W-1:0] iw_reg, iw_next, qw_reg, qw_next;
  logic              pv_reg, pv_next;

  // Decoded controls
  logic global_pd, auto_pd, gate_eff, interleave, zstuff, bad_cfg, il_mode;
  logic engine_on, flush_word;
  logic [1:0] interp;

  assign preq       = tgp_pkg::tgp_pwr_req_t'(pwr_reg[6:0]);
  assign global_pd  = ctrl_reg[tgp_pkg::CTRL_GLOBAL_PD];
  assign auto_pd    = ctrl_reg[tgp_pkg::CTRL_AUTO_PD];
  assign gate_eff   = gate_s2_reg ^ gate_reg[tgp_pkg::GATE_INVERT];
  assign interleave = mode_reg[tgp_pkg::MODE_INTERLEAVE];
  assign interp     = mode_reg[tgp_pkg::MODE_INTERP_LO +: 2];
  assign zstuff     = mode_reg[tgp_pkg::MODE_ZERO_STUFF];
  // Invalid combination falls back to dual-port handling
  assign bad_cfg    = interleave & (interp == tgp_pkg::INTERP_1X) & ~zstuff;
  assign il_mode    = interleave & ~bad_cfg;

  // Bus request and single wait cycle
  assign req         = read | write;
  assign idx         = address[4:2];
  assign waitrequest = req & ~ack_reg;
  assign readdata    = rdata_reg;

  // Status view of the block's own state
  assign status = {27'h0, gate_eff, bad_cfg, aligned_reg,
                   state_reg == tgp_pkg::ST_FLUSH, engine_on};

  // Register next values; writes land on the answer edge, read data one edge earlier
  always_comb begin
    ctrl_next  = ctrl_reg;
    pwr_next   = pwr_reg;
    gate_next  = gate_reg;
    mode_next  = mode_reg;
    rdata_next = rdata_reg;
    ack_next   = req & ~ack_reg;
    if (req && !ack_reg) begin
      rdata_next = 32'h0;
      if (read) begin
        unique case (idx)
          tgp_pkg::IDX_CTRL:   rdata_next = {24'h0, ctrl_reg};
          tgp_pkg::IDX_POWER:  rdata_next = {24'h0, pwr_reg};
          tgp_pkg::IDX_GATE:   rdata_next = {24'h0, gate_reg};
          tgp_pkg::IDX_MODE:   rdata_next = {16'h0, mode_reg};
          tgp_pkg::IDX_STATUS: rdata_next = status;
          default:             rdata_next = 32'h0;
        endcase
      end
    end
    if (write && ack_reg && byteenable[0]) begin
      unique case (idx)
        tgp_pkg::IDX_CTRL:  ctrl_next = writedata[7:0] & 8'h18;
        tgp_pkg::IDX_POWER: pwr_next  = writedata[7:0] & 8'h7f;
        tgp_pkg::IDX_GATE:  gate_next = writedata[7:0] & 8'h03;
        tgp_pkg::IDX_MODE:  mode_next[7:0] = writedata[7:0] & 8'h0f;
        default:            ;
      endcase
    end
    if (write && ack_reg && byteenable[1] && idx == tgp_pkg::IDX_MODE) begin
      mode_next[15:8] = writedata[15:8];
    end
  end

  // Register state
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_reg  <= tgp_pkg::CTRL_RST;
      pwr_reg   <= tgp_pkg::POWER_RST;
      gate_reg  <= tgp_pkg::GATE_RST;
      mode_reg  <= tgp_pkg::MODE_RST;
      rdata_reg <= 32'h0;
      ack_reg   <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      pwr_reg   <= pwr_next;
      gate_reg  <= gate_next;
      mode_reg  <= mode_next;
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
    end
  end

  // Pins from the data source are asynchronous to sys_clk
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      gate_s1_reg <= 1'b0;
      gate_s2_reg <= 1'b0;
      p1_s1_reg   <= '0;
      p1_s2_reg   <= '0;
      p2_s1_reg   <= '0;
      p2_s2_reg   <= '0;
    end else begin
      gate_s1_reg <= transmit_gate;
      gate_s2_reg <= gate_s1_reg;
      p1_s1_reg   <= data_port1;
      p1_s2_reg   <= p1_s1_reg;
      p2_s1_reg   <= data_port2;
      p2_s2_reg   <= p2_s1_reg;
    end
  end

  // Word clock divider; stops only under global power-down
  always_comb begin
    wdiv_next = wdiv_reg + 8'h01;
    wclk_next = wclk_reg;
    rise_en   = 1'b0;
    if (global_pd) begin
      wdiv_next = 8'h00;
      wclk_next = 1'b0;
    end else if (wdiv_reg + 8'h01 >= mode_reg[tgp_pkg::MODE_HALF_LO +: 8]) begin
      wdiv_next = 8'h00;
      wclk_next = ~wclk_reg;
      rise_en   = ~wclk_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wdiv_reg <= 8'h00;
      wclk_reg <= 1'b0;
    end else begin
      wdiv_reg <= wdiv_next;
      wclk_reg <= wclk_next;
    end
  end

  assign word_clock_out = wclk_reg;

  // Flush length follows the interpolation filter chain
  always_comb begin
    unique case (interp)
      tgp_pkg::INTERP_1X: flush_lim = 16'(FLUSH_1X);
      tgp_pkg::INTERP_2X: flush_lim = 16'(FLUSH_2X);
      tgp_pkg::INTERP_4X: flush_lim = 16'(FLUSH_4X);
      default:            flush_lim = 16'(FLUSH_8X);
    endcase
  end

  // Gate-driven flush and digital power-down; one reference cycle per clock
  always_comb begin
    state_next = state_reg;
    fcnt_next  = fcnt_reg;
    unique case (state_reg)
      tgp_pkg::ST_RUN: begin
        fcnt_next = 16'h0000;
        if (!gate_eff) begin
          state_next = tgp_pkg::ST_FLUSH;
        end
      end
      tgp_pkg::ST_FLUSH: begin
        if (gate_eff) begin
          state_next = tgp_pkg::ST_RUN;
        end else if (auto_pd && fcnt_reg + 16'h0001 >= flush_lim) begin
          state_next = tgp_pkg::ST_DOWN;
        end else if (fcnt_reg + 16'h0001 < flush_lim) begin
          fcnt_next = fcnt_reg + 16'h0001;
        end
      end
      tgp_pkg::ST_DOWN: begin
        if (gate_eff) begin
          state_next = tgp_pkg::ST_RUN;
        end else if (!auto_pd) begin
          state_next = tgp_pkg::ST_FLUSH;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg <= tgp_pkg::ST_RUN;
      fcnt_reg  <= 16'h0000;
    end else begin
      state_reg <= state_next;
      fcnt_reg  <= fcnt_next;
    end
  end

  // Engine runs unless gate, software or global power-down stops it
  assign engine_on = ~global_pd & ~preq.digital_pd
                   & (state_reg != tgp_pkg::ST_DOWN);

  // Power outputs; auto power-down leaves converters and reference alone
  always_comb begin
    power.reference_on         = ~global_pd;
    power.main_converter_on    = ~global_pd & ~preq.main_pd;
    power.main_converter_sleep = ~global_pd & ~preq.main_pd
                               & preq.main_sleep;
    power.aux_converter_pd     = {global_pd | preq.aux2_pd,
                                  global_pd | preq.aux1_pd};
    power.aux_converter_sleep  = {preq.aux2_sleep, preq.aux1_sleep};
    power.digital_engine_on    = engine_on;
  end

  // Interleaved words with gate low count as data only right after a high
  // word, so toggle-per-cycle sources keep their Q words
  assign flush_word = ~gate_eff & (~il_mode | pgate_reg == 1'b0);

  // Word capture and I/Q pairing on each word clock rise
  always_comb begin
    pgate_next   = pgate_reg;
    sel_q_next   = sel_q_reg;
    aligned_next = aligned_reg;
    haveq_next   = haveq_reg;
    hold_next    = hold_reg;
    iw_next      = iw_reg;
    qw_next      = qw_reg;
    pv_next      = 1'b0;
    if (!engine_on) begin
      iw_next      = '0;
      qw_next      = '0;
      aligned_next = 1'b0;
      haveq_next   = 1'b0;
    end else if (rise_en) begin
      pgate_next = gate_eff;
      if (flush_word) begin
        iw_next      = '0;
        qw_next      = '0;
        pv_next      = 1'b1;
        aligned_next = 1'b0;
        haveq_next   = 1'b0;
      end else if (!il_mode) begin
        iw_next = p1_s2_reg;
        qw_next = p2_s2_reg;
        pv_next = 1'b1;
      end else begin
        // Gate rise marks an I word on port one
        if (gate_eff && !pgate_reg) begin
          sel_q_next   = 1'b1;
          aligned_next = 1'b1;
          haveq_next   = 1'b0;
          hold_next    = p1_s2_reg;
        end else if (!sel_q_reg) begin
          sel_q_next = 1'b1;
          if (gate_reg[tgp_pkg::GATE_Q_FIRST] && haveq_reg) begin
            iw_next = p1_s2_reg;
            qw_next = hold_reg;
            pv_next = 1'b1;
          end else begin
            hold_next = p1_s2_reg;
          end
        end else begin
          sel_q_next = 1'b0;
          if (gate_reg[tgp_pkg::GATE_Q_FIRST]) begin
            hold_next  = p1_s2_reg;
            haveq_next = 1'b1;
          end else begin
            iw_next = hold_reg;
            qw_next = p1_s2_reg;
            pv_next = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pgate_reg   <= 1'b0;
      sel_q_reg   <= 1'b0;
      aligned_reg <= 1'b0;
      haveq_reg   <= 1'b0;
      hold_reg    <= '0;
      iw_reg      <= '0;
      qw_reg      <= '0;
      pv_reg      <= 1'b0;
    end else begin
      pgate_reg   <= pgate_next;
      sel_q_reg   <= sel_q_next;
      aligned_reg <= aligned_next;
      haveq_reg   <= haveq_next;
      hold_reg    <= hold_next;
      iw_reg      <= iw_next;
      qw_reg      <= qw_next;
      pv_reg      <= pv_next;
    end
  end

  assign i_word     = iw_reg;
  assign q_word     = qw_reg;
  assign pair_valid = pv_reg;
endmodule // tgp_ctrl

// file: logic/tgp_pkg.sv
// Overview of operation
// - Global power-down stops all analog and digital parts; bus stays alive.
// - Sleep turns main converter output off but keeps the reference powered.
// - Digital engine, main and aux converters power down singly or together.
// - Auxiliary converters have their own software-set sleep state.
// - Auto power-down bit picks flush-only or flush then digital power-down.
// - Gate low without auto power-down feeds zeros; gate high runs normally.
// - Gate low with auto power-down flushes, then powers down digital engine.
// - Gate-invert bit reverses gate polarity for every use of the gate.
// - Dual-port mode uses the gate only for zero flush and digital power-down, not alignment.
// - Word clock rise with gate high fixes I/Q alignment; held while high.
// - Gate toggled once per input cycle re-aligns I/Q on every gate rise.
// - Gate-low to power-down cycles equal flush time of chosen interpolation.
// - Q-first zero pairs I1Q1, I2Q2; one drops first I, pairs I2Q1. With the gate toggled per input cycle, Q-first one gives no pairs.
// - I words always go to the I channel and Q words to Q.
// - Input words are captured on the rising edge of the word clock output.
// - Interleaved mode with interpolation one and no zero stuffing is invalid.
package tgp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_CTRL   = 3'h0;
  localparam logic [2:0] IDX_POWER  = 3'h1;
  localparam logic [2:0] IDX_GATE   = 3'h2;
  localparam logic [2:0] IDX_MODE   = 3'h3;
  localparam logic [2:0] IDX_STATUS = 3'h4;
  // Field positions
  localparam int CTRL_GLOBAL_PD  = 4;
  localparam int CTRL_AUTO_PD    = 3;
  localparam int GATE_INVERT     = 1;
  localparam int GATE_Q_FIRST    = 0;
  localparam int MODE_INTERLEAVE = 0;
  localparam int MODE_INTERP_LO  = 1;
  localparam int MODE_ZERO_STUFF = 3;
  localparam int MODE_HALF_LO    = 8;
  // Reset values
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  POWER_RST = 8'h00;
  localparam logic [7:0]  GATE_RST  = 8'h00;
  localparam logic [15:0] MODE_RST  = 16'h1403;
  // Interpolation select codes
  localparam logic [1:0] INTERP_1X = 2'h0;
  localparam logic [1:0] INTERP_2X = 2'h1;
  localparam logic [1:0] INTERP_4X = 2'h2;
  // Bus answer latency in clock cycles after the request is seen
  localparam int BUS_WAIT = 1;

  typedef enum {ST_RUN, ST_FLUSH, ST_DOWN} tgp_state_t;

  // Power enables driven to the analog parts and the digital engine
  typedef struct packed {
    logic       reference_on;
    logic       main_converter_on;
    logic       main_converter_sleep;
    logic [1:0] aux_converter_pd;
    logic [1:0] aux_converter_sleep;
    logic       digital_engine_on;
  } tgp_power_t;

  // Software power request bits, register index 1
  typedef struct packed {
    logic       aux2_sleep;
    logic       aux1_sleep;
    logic       aux2_pd;
    logic       aux1_pd;
    logic       main_sleep;
    logic       main_pd;
    logic       digital_pd;
  } tgp_pwr_req_t;
endpackage

// file: sim/tgp_ctrl_sva.sv
`timescale 1ns/1ps
module tgp_ctrl_sva #(
  parameter int DATA_W = 16
) (
  input wire logic                sys_clk,
  input wire logic                nrst,
  input wire logic [4:0]          address,
  input wire logic                read,
  input wire logic                write,
  input wire logic [31:0]         writedata,
  input wire logic [3:0]          byteenable,
  input wire logic [31:0]         readdata,
  input wire logic                waitrequest,
  input wire logic                word_clock_out,
  input wire logic [DATA_W-1:0]   i_word,
  input wire logic [DATA_W-1:0]   q_word,
  input wire logic                pair_valid,
  input wire tgp_pkg::tgp_power_t power
);
  // Completed byte-lane-0 writes, decoded per register
  wire take     = write && !waitrequest && byteenable[0];
  wire ctrl_wr  = take && address[4:2] == tgp_pkg::IDX_CTRL;
  wire power_wr = take && address[4:2] == tgp_pkg::IDX_POWER;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered in one cycle");
  a_idle_nowait: assert property (!read && !write |-> !waitrequest)
    else $error("wait raised without a request");
  a_global_pd: assert property (ctrl_wr && writedata[4] |=> !power.reference_on && !power.main_converter_on && !power.digital_engine_on)
    else $error("global power-down left a part running");
  a_global_wake: assert property (ctrl_wr && !writedata[4] |=> power.reference_on)
    else $error("reference stayed off after global power-up");
  a_digital_pd: assert property (power_wr && writedata[0] |=> !power.digital_engine_on)
    else $error("digital power-down request ignored");
  a_sleep_ref: assert property (power.main_converter_sleep |-> power.reference_on)
    else $error("reference off during sleep");
  a_wclk_stops: assert property (!power.reference_on [*2] |=> $stable(word_clock_out))
    else $error("word clock runs in global power-down");
  a_pair_pulse: assert property (pair_valid |=> !pair_valid)
    else $error("pair strobe longer than one cycle");
  a_pair_in_high: assert property (pair_valid |-> word_clock_out)
    else $error("pair not tied to a word clock rise");
  a_engine_off_zero: assert property (!power.digital_engine_on [*3] |-> !pair_valid && i_word == '0 && q_word == '0)
    else $error("output activity with engine off");
  a_read_unmapped: assert property (read && !waitrequest && address[4:2] > 3'h4 |-> readdata == 32'h0)
    else $error("unmapped read not zero");

  c_pair: cover property (pair_valid && i_word != '0);
  c_auto_off: cover property ($fell(power.digital_engine_on));
  c_read: cover property (read && !waitrequest);
endmodule // tgp_ctrl_sva

bind tgp_ctrl tgp_ctrl_sva #(.DATA_W(DATA_W)) i_sva (
  .sys_clk(sys_clk), .nrst(nrst), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest),
  .word_clock_out(word_clock_out), .i_word(i_word), .q_word(q_word),
  .pair_valid(pair_valid), .power(power)
);

// file: sim/tgp_source.sv
`timescale 1ns/1ps
module tgp_source #(
  parameter int DATA_W = 16
) (
  input  wire logic         word_clock_out,
  input  wire logic         run,
  input  wire logic         dual,
  input  wire logic         toggle,
  output logic              transmit_gate,
  output logic [DATA_W-1:0] data_port1,
  output logic [DATA_W-1:0] data_port2
);
  int   k;
  logic on_q;

  // Word value carries its channel and index, so pairing is visible
  function automatic logic [DATA_W-1:0] word(input logic q, input int n);
    return DATA_W'(q ? 32'h2000 + n : 32'h1000 + n);
  endfunction

  initial begin
    k = 1;
    on_q = 1'b0;
    transmit_gate = 1'b0;
    data_port1 = word(1'b0, 1);
    data_port2 = ~data_port1;
  end

  // Gate and words move together just after each word clock rise
  // Timed against the word clock output alone, so no sync input is needed
  always @(posedge word_clock_out) begin
    if (!run) begin
      k = 1;
      on_q = 1'b0;
      transmit_gate <= 1'b0;
    end else if (dual) begin
      if (transmit_gate) k = k + 1;
      transmit_gate <= 1'b1;
    end else if (!transmit_gate && !on_q) begin
      transmit_gate <= 1'b1;
    end else if (on_q) begin
      k = k + 1;
      on_q = 1'b0;
      transmit_gate <= 1'b1;
    end else begin
      on_q = 1'b1;
      transmit_gate <= !toggle;
    end
    data_port1 <= word(on_q, k);
    // Unused port flips each word so stale values never look valid
    data_port2 <= dual ? word(1'b1, k) : ~word(on_q, k);
  end
endmodule // tgp_source

// file: sim/tb_tx_gate_powerdown_iq_sync.sv
`timescale 1ns/1ps
module tb_tx_gate_powerdown_iq_sync;
  localparam int FL[4] = '{4, 5, 6, 7};
  logic                sys_clk = 1'b0;
  logic                nrst, read, write, run, dual, toggle;
  logic [4:0]          address;
  logic [31:0]         writedata, readdata, rdv;
  logic [3:0]          byteenable;
  logic                waitrequest, transmit_gate, word_clock_out, pair_valid;
  logic [15:0]         data_port1, data_port2, i_word, q_word;
  tgp_pkg::tgp_power_t power, ex;
  logic [6:0]          v;
  logic [31:0]         got[$];
  int                  zp, miscompares, checked, cyc, n;
  int                  lat[4];

  tgp_ctrl #(.FLUSH_1X(FL[0]), .FLUSH_2X(FL[1]), .FLUSH_4X(FL[2]),
    .FLUSH_8X(FL[3])) i_dut (.sys_clk(sys_clk), .nrst(nrst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .transmit_gate(transmit_gate),
    .data_port1(data_port1), .data_port2(data_port2),
    .word_clock_out(word_clock_out), .i_word(i_word), .q_word(q_word),
    .pair_valid(pair_valid), .power(power));
  tgp_source i_src (.word_clock_out(word_clock_out), .run(run), .dual(dual),
    .toggle(toggle), .transmit_gate(transmit_gate),
    .data_port1(data_port1), .data_port2(data_port2));

  always #2 sys_clk = !sys_clk;

  // Pair monitor and hang guard; zero pairs are the flush output
  always @(posedge sys_clk) begin
    cyc++;
    if (pair_valid === 1'b1 && {i_word, q_word} === 32'h0) zp++;
    else if (pair_valid === 1'b1) got.push_back({i_word, q_word});
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held until waitrequest is seen low at an edge
  task automatic acc(input logic wr_en, input logic [2:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    read <= !wr_en;
    write <= wr_en;
    address <= {idx, 2'h0};
    writedata <= wd;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // Extra edge lets the written register reach the outputs
  task automatic wr(input logic [2:0] idx, input logic [31:0] wd);
    logic [31:0] x;
    acc(1'b1, idx, wd, x);
    @(posedge sys_clk);
  endtask

  task automatic wait_eng(input logic val);
    n = 0;
    while (power.digital_engine_on !== val && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  // Idle with gate low, then start the source and check three pairs
  task automatic stream(input logic qf, input logic dl, input logic tg);
    wr(tgp_pkg::IDX_GATE, {31'h0, qf});
    wr(tgp_pkg::IDX_MODE, dl ? 32'h1402 : 32'h1403);
    dual <= dl;
    toggle <= tg;
    run <= 1'b0;
    zp = 0;
    repeat (200) @(posedge sys_clk);
    chk("zero flush pairs", 32'(zp > 0), 32'h1);
    got.delete();
    run <= 1'b1;
    n = 0;
    while (got.size() < 3 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    for (int k = 0; k < 3; k++)
      chk("pair", got.size() > k ? got[k] : 32'hx, {16'(32'h1001 + k + (qf && !dl)), 16'(32'h2001 + k)});
  endtask

  task automatic tally_and_finish;
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    {nrst, read, write, run, dual, toggle} = 6'h0;
    {address, writedata} = 37'h0;
    byteenable = 4'hf;
    zp = 0;
    miscompares = 0;
    checked = 0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      acc(1'b0, 3'(r), 32'h0, rdv);
      chk("reset value", rdv, r == 3 ? 32'(tgp_pkg::MODE_RST) : 32'h0);
    end
    wr(3'h6, 32'hffffffff);
    acc(1'b0, 3'h6, 32'h0, rdv);
    chk("unmapped", rdv, 32'h0);
    for (int b = 0; b < 8; b++) begin
      v = b == 7 ? 7'h7f : 7'(1 << b);
      wr(tgp_pkg::IDX_POWER, 32'(v));
      ex = '{1'b1, !v[1], v[2] && !v[1], v[4:3], v[6:5], !v[0]};
      chk("power", 32'(power), 32'(ex));
    end
    wr(tgp_pkg::IDX_POWER, 32'h0);
    wr(tgp_pkg::IDX_CTRL, 32'h10);
    chk("global pd", 32'({power.reference_on, power.main_converter_on, power.digital_engine_on}), 32'h0);
    acc(1'b0, tgp_pkg::IDX_CTRL, 32'h0, rdv);
    chk("bus alive", rdv, 32'h10);
    wr(tgp_pkg::IDX_CTRL, 32'h0);
    wr(tgp_pkg::IDX_MODE, 32'h1401);
    acc(1'b0, tgp_pkg::IDX_STATUS, 32'h0, rdv);
    chk("invalid mode", 32'(rdv[3]), 32'h1);
    stream(1'b0, 1'b0, 1'b0);
    stream(1'b1, 1'b0, 1'b0);
    stream(1'b0, 1'b0, 1'b1);
    stream(1'b0, 1'b1, 1'b0);
    wr(tgp_pkg::IDX_CTRL, 32'h08);
    for (int c = 0; c < 4; c++) begin
      wr(tgp_pkg::IDX_MODE, 32'h1400 | 32'(c << 1));
      run <= 1'b1;
      wait_eng(1'b1);
      chk("engine back", 32'(power.digital_engine_on), 32'h1);
      repeat (100) @(posedge sys_clk);
      run <= 1'b0;
      @(posedge sys_clk);
      while (transmit_gate !== 1'b0) @(posedge sys_clk);
      wait_eng(1'b0);
      lat[c] = n;
      chk("converters on", 32'({power.reference_on, power.main_converter_on}), 32'h3);
      chk("flush time", 32'(lat[c] - lat[0]), 32'(FL[c] - FL[0]));
    end
    wr(tgp_pkg::IDX_GATE, 32'h2);
    wait_eng(1'b1);
    chk("inverted low gate", 32'(power.digital_engine_on), 32'h1);
    acc(1'b0, tgp_pkg::IDX_STATUS, 32'h0, rdv);
    chk("effective gate", 32'(rdv[4]), 32'h1);
    run <= 1'b1;
    wait_eng(1'b0);
    chk("inverted high gate", 32'(power.digital_engine_on), 32'h0);
    tally_and_finish();
  end
endmodule // tb_tx_gate_powerdown_iq_sync
